// [pkg/fccc_pkg.sv]
// Shared constants and types for the flash card command interpreter
package fccc_pkg;
	// Bus widths
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	// Attribute register addresses
	localparam logic [15:0] CARD_STATUS_ADDR = 16'h4100;
	localparam logic [15:0] WR_PROT_ADDR = 16'h4104;
	localparam logic [15:0] VOLT_CTRL_ADDR = 16'h410c;
	// Attribute information structure ends here (exclusive)
	localparam logic [15:0] ATTR_CIS_END = 16'h4000;
	// Common information structure ends here (exclusive)
	localparam logic [15:0] COMMON_CIS_END = 16'h0400;
	// Card status fields
	localparam int CS_READY = 0;
	localparam int CS_WP_SWITCH = 1;
	localparam int CS_INFO_STRUCTURE_WRITE_PROTECT = 2;
	localparam int CS_PWRDN = 3;
	localparam int CS_COMMON_ARRAY_WRITE_PROTECT = 4;
	localparam int CS_SOFT_RESET_FLAG = 5;
	// Write protection fields
	localparam int WP_CIS = 0;
	localparam int WP_COMMON = 1;
	localparam int WP_BLOCK_EN = 2;
	localparam int WP_BITS = 3;
	localparam logic [2:0] WP_RESET = 3'h0;
	// Voltage control fields
	localparam int VC_GEN = 0;
	localparam int VC_VALID = 1;
	localparam int VC_LEVEL = 7;
	localparam logic VC_GEN_RESET = 1'b0;
	// Lock bit inside a block status byte
	localparam int BSR_LOCK = 6;
	// Command codes
	localparam logic [7:0] C_WRITE = 8'h40;
	localparam logic [7:0] C_WRITE_ALT = 8'h10;
	localparam logic [7:0] C_ERASE = 8'h20;
	localparam logic [7:0] C_CLEAR = 8'h50;
	localparam logic [7:0] C_RD_CSR = 8'h70;
	localparam logic [7:0] C_RD_EXT = 8'h71;
	localparam logic [7:0] C_RD_ID = 8'h90;
	localparam logic [7:0] C_SUSPEND = 8'hb0;
	localparam logic [7:0] C_CONFIRM = 8'hd0;
	localparam logic [7:0] C_RD_ARRAY = 8'hff;
	localparam logic [7:0] C_PB_XFER = 8'h0c;
	localparam logic [7:0] C_PB_SINGLE = 8'h74;
	localparam logic [7:0] C_RB_CFG = 8'h96;
	localparam logic [7:0] C_UPLOAD = 8'h97;
	localparam logic [7:0] C_ERASE_ALL = 8'ha7;
	localparam logic [7:0] C_PB_SEQ = 8'he0;
	// Ready/busy sub-codes
	localparam logic [7:0] RB_SUB_LEVEL = 8'h01;
	localparam logic [7:0] RB_SUB_PWRITE = 8'h02;
	localparam logic [7:0] RB_SUB_PERASE = 8'h03;
	localparam logic [7:0] RB_SUB_OFF = 8'h04;
	// Ready/busy pulse width
	localparam int RB_PULSE_NS = 250;
	localparam int CLK_NS = 50;
	localparam int RB_PULSE_CYC = (RB_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] RB_PULSE_LEN = 4'(RB_PULSE_CYC);

	// Ready/busy output modes
	typedef enum logic [1:0] {
		RB_LEVEL = 2'h0,
		RB_PWRITE = 2'h1,
		RB_PERASE = 2'h2,
		RB_OFF = 2'h3
	} fccc_rb_mode_t;

	// Host read selection
	typedef enum logic [1:0] {
		RD_ARRAY = 2'h0,
		RD_ID = 2'h1,
		RD_CSR = 2'h2,
		RD_EXT = 2'h3
	} fccc_rd_mode_t;

	// Operations handed to the flash array
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_WRITE = 4'h1,
		OP_ERASE = 4'h2,
		OP_ERASE_ALL = 4'h3,
		OP_SUSPEND = 4'h4,
		OP_RESUME = 4'h5,
		OP_CLEAR = 4'h6,
		OP_PB_SEQ_CNT = 4'h7,
		OP_PB_LOAD = 4'h8,
		OP_PB_XFER = 4'h9,
		OP_UPLOAD = 4'ha
	} fccc_op_t;

	// One queued array request
	typedef struct packed {
		logic valid;
		fccc_op_t op;
		logic [15:0] addr;
		logic [15:0] aux;
		logic [7:0] data;
	} fccc_req_t;

	// Host bus pins after synchronising
	typedef struct packed {
		logic ce_n;
		logic reg_n;
		logic oe_n;
		logic we_n;
		logic [15:0] addr;
		logic [7:0] data;
	} fccc_pins_t;
endpackage

// [hw/fccc_card_ctrl.sv]
// Card-side command interpreter and management registers
`timescale 1ns/10ps
`default_nettype none
module fccc_card_ctrl
(
	input wire logic mclk, // System clock, 20 MHz
	input wire logic rst, // Asynchronous reset, high
	input wire logic ce_n, // Card enable pin
	input wire logic reg_n, // Attribute plane select pin
	input wire logic oe_n, // Output enable pin
	input wire logic we_n, // Write enable pin
	input wire logic [15:0] addr, // Address pins
	input wire logic [7:0] data_in, // Data pins, inbound
	output logic [7:0] data_out, // Data pins, outbound
	output logic data_oe, // Data pins driven
	input wire logic vcc_3v3, // Host supplies 3.3V
	input wire logic wp_switch, // Mechanical protect switch
	input wire logic soft_reset_flag, // Soft reset state
	input wire logic power_down_flag, // Power-down state
	input wire logic gen_valid, // Generator output in range
	input wire logic array_busy, // Array working
	input wire logic [7:0] array_rdata, // Array read data
	input wire logic [7:0] id_rdata, // Identifier data
	input wire logic [7:0] csr_rdata, // Compatible status
	input wire logic [7:0] ext_rdata, // Global/block status
	output fccc_pkg::fccc_req_t req, // Request to array
	output logic block_lock_enable, // Per-block locking on
	output logic prog_voltage_generator_on, // Generator on
	output logic locks_uploaded, // Lock states loaded
	output logic attr_write, // Attribute CIS write pulse
	output logic ready_busy_output // Ready/busy pin
);
	// Command sequencer states
	typedef enum logic [11:0] {
		ST_IDLE = 12'h001,
		ST_WDATA = 12'h002,
		ST_ERS_CF = 12'h004,
		ST_ALL_CF = 12'h008,
		ST_UPL_CF = 12'h010,
		ST_SEQ_LO = 12'h020,
		ST_SEQ_HI = 12'h040,
		ST_SEQ_DAT = 12'h080,
		ST_XF_LO = 12'h100,
		ST_XF_HI = 12'h200,
		ST_SGL = 12'h400,
		ST_RB_SUB = 12'h800
	} fccc_state_t;

	fccc_pkg::fccc_pins_t pin_raw; // Pins as they arrive
	fccc_pkg::fccc_pins_t sync1_r; // First stage only
	fccc_pkg::fccc_pins_t sync2_r; // Safe to use
	fccc_pkg::fccc_pins_t prev_r; // For edge detection
	logic [3:0] lvl1_r; // Status level first stage
	logic [3:0] lvl2_r; // Status level second stage
	fccc_state_t state_r, state_nxt; // Sequencer
	logic [2:0] wp_r; // Write protection bits
	logic vgen_r; // Generator switch
	logic locks_r; // Lock upload done
	fccc_pkg::fccc_rb_mode_t rb_mode_r, rb_mode_nxt;
	fccc_pkg::fccc_rd_mode_t rd_mode_r, rd_mode_nxt;
	fccc_pkg::fccc_req_t req_r, req_nxt;
	logic [15:0] lo_addr_r, lo_addr_nxt; // Count-low address
	logic [7:0] cnt_r, cnt_nxt; // Sequential load count
	logic last_erase_r; // Last array op kind
	logic busy_prev_r; // Busy delayed
	logic [3:0] pulse_r; // Pulse countdown
	logic [7:0] dout_r; // Read data register
	logic attr_wr_r; // Attribute write pulse

	// Synchronised levels
	wire s_vcc = lvl2_r[0];
	wire s_wps = lvl2_r[1];
	wire s_gen = lvl2_r[2];
	wire s_busy = lvl2_r[3];

	// Strobe decode
	wire sel = !sync2_r.ce_n;
	wire wr_take = sel && !prev_r.we_n && sync2_r.we_n;
	wire attr = !prev_r.reg_n;
	wire com_wr = wr_take && !attr;
	wire attr_wr = wr_take && attr;
	wire [15:0] wa = prev_r.addr;
	wire [7:0] wd = prev_r.data;
	wire hit_wp = wa == fccc_pkg::WR_PROT_ADDR;
	wire hit_vc = wa == fccc_pkg::VOLT_CTRL_ADDR;
	wire in_acis = wa < fccc_pkg::ATTR_CIS_END;
	// Protected common region: everything past the common CIS
	wire com_prot = wp_r[fccc_pkg::WP_COMMON] &&
		(wa >= fccc_pkg::COMMON_CIS_END);

	// Register read views
	// Reset, protect, power-down flags
	wire [7:0] card_status = {2'h0, soft_reset_flag,
		wp_r[fccc_pkg::WP_COMMON], power_down_flag,
		wp_r[fccc_pkg::WP_CIS], s_wps, !s_busy};
	wire [7:0] volt_ctrl = {s_vcc, 5'h00, s_gen, vgen_r};
	wire [7:0] ext_view = locks_r ? ext_rdata :
		(ext_rdata | (8'h01 << fccc_pkg::BSR_LOCK));

	assign pin_raw = '{ce_n: ce_n, reg_n: reg_n, oe_n: oe_n,
		we_n: we_n, addr: addr, data: data_in};

	// Two-flop synchroniser for bus pins and four levels; soft_reset_flag and power_down_flag bypass it
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			sync1_r <= '{ce_n: 1'b1, reg_n: 1'b1, oe_n: 1'b1,
				we_n: 1'b1, addr: 16'h0000, data: 8'h00};
			sync2_r <= '{ce_n: 1'b1, reg_n: 1'b1, oe_n: 1'b1,
				we_n: 1'b1, addr: 16'h0000, data: 8'h00};
			prev_r <= '{ce_n: 1'b1, reg_n: 1'b1, oe_n: 1'b1,
				we_n: 1'b1, addr: 16'h0000, data: 8'h00};
			lvl1_r <= 4'h0;
			lvl2_r <= 4'h0;
		end
		else
		begin
			sync1_r <= pin_raw;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
			lvl1_r <= {array_busy, gen_valid, wp_switch, vcc_3v3};
			lvl2_r <= lvl1_r;
		end
	end

	// Command decoding; writes land on the rising write strobe
	always_comb
	begin
		state_nxt = state_r;
		rb_mode_nxt = rb_mode_r;
		rd_mode_nxt = rd_mode_r;
		lo_addr_nxt = lo_addr_r;
		cnt_nxt = cnt_r;
		req_nxt = '{valid: 1'b0, op: fccc_pkg::OP_NONE,
			addr: wa, aux: 16'h0000, data: wd};
		if (com_wr)
		begin
			case (state_r)
				ST_IDLE:
				begin
					case (wd)
						fccc_pkg::C_WRITE,
						fccc_pkg::C_WRITE_ALT:
							state_nxt = ST_WDATA;
						fccc_pkg::C_ERASE:
							state_nxt = ST_ERS_CF;
						fccc_pkg::C_ERASE_ALL:
							state_nxt = ST_ALL_CF;
						fccc_pkg::C_UPLOAD:
							state_nxt = ST_UPL_CF;
						fccc_pkg::C_PB_SEQ:
							state_nxt = ST_SEQ_LO;
						fccc_pkg::C_PB_XFER:
							state_nxt = ST_XF_LO;
						fccc_pkg::C_PB_SINGLE:
							state_nxt = ST_SGL;
						fccc_pkg::C_RB_CFG:
							state_nxt = ST_RB_SUB;
						fccc_pkg::C_SUSPEND:
						begin
							req_nxt.valid = 1'b1;
							req_nxt.op = fccc_pkg::OP_SUSPEND;
						end
						fccc_pkg::C_CONFIRM:
						begin
							req_nxt.valid = 1'b1;
							req_nxt.op = fccc_pkg::OP_RESUME;
						end
						fccc_pkg::C_CLEAR:
						begin
							req_nxt.valid = 1'b1;
							req_nxt.op = fccc_pkg::OP_CLEAR;
						end
						fccc_pkg::C_RD_ARRAY:
							rd_mode_nxt = fccc_pkg::RD_ARRAY;
						fccc_pkg::C_RD_ID:
							rd_mode_nxt = fccc_pkg::RD_ID;
						fccc_pkg::C_RD_CSR:
							rd_mode_nxt = fccc_pkg::RD_CSR;
						fccc_pkg::C_RD_EXT:
							rd_mode_nxt = fccc_pkg::RD_EXT;
						// Unknown codes are ignored
						default:
							state_nxt = ST_IDLE;
					endcase
				end
				ST_WDATA:
				begin
					req_nxt.valid = !com_prot;
					req_nxt.op = fccc_pkg::OP_WRITE;
					state_nxt = ST_IDLE;
				end
				ST_ERS_CF:
				begin
					req_nxt.valid = (wd == fccc_pkg::C_CONFIRM) &&
						!com_prot;
					req_nxt.op = fccc_pkg::OP_ERASE;
					state_nxt = ST_IDLE;
				end
				ST_ALL_CF:
				begin
					req_nxt.valid = (wd == fccc_pkg::C_CONFIRM) &&
						!wp_r[fccc_pkg::WP_COMMON];
					req_nxt.op = fccc_pkg::OP_ERASE_ALL;
					state_nxt = ST_IDLE;
				end
				ST_UPL_CF:
				begin
					req_nxt.valid = wd == fccc_pkg::C_CONFIRM;
					req_nxt.op = fccc_pkg::OP_UPLOAD;
					state_nxt = ST_IDLE;
				end
				ST_SEQ_LO:
				begin
					cnt_nxt = wd;
					state_nxt = ST_SEQ_HI;
				end
				ST_SEQ_HI:
				begin
					req_nxt.valid = 1'b1;
					req_nxt.op = fccc_pkg::OP_PB_SEQ_CNT;
					req_nxt.aux = {wd, cnt_r};
					state_nxt = ST_SEQ_DAT;
				end
				ST_SEQ_DAT:
				begin
					req_nxt.valid = 1'b1;
					req_nxt.op = fccc_pkg::OP_PB_LOAD;
					cnt_nxt = cnt_r - 8'h01;
					if (cnt_r == 8'h00)
						state_nxt = ST_IDLE;
				end
				ST_XF_LO:
				begin
					cnt_nxt = wd;
					lo_addr_nxt = wa;
					state_nxt = ST_XF_HI;
				end
				ST_XF_HI:
				begin
					req_nxt.valid = !com_prot;
					req_nxt.op = fccc_pkg::OP_PB_XFER;
					// High count sits at flipped A0
					req_nxt.aux = {lo_addr_r[15:1], ~lo_addr_r[0]};
					// High byte assumed zero by host
					req_nxt.data = cnt_r;
					state_nxt = ST_IDLE;
				end
				ST_SGL:
				begin
					req_nxt.valid = 1'b1;
					req_nxt.op = fccc_pkg::OP_PB_LOAD;
					state_nxt = ST_IDLE;
				end
				ST_RB_SUB:
				begin
					case (wd)
						fccc_pkg::RB_SUB_LEVEL:
							rb_mode_nxt = fccc_pkg::RB_LEVEL;
						fccc_pkg::RB_SUB_PWRITE:
							rb_mode_nxt = fccc_pkg::RB_PWRITE;
						fccc_pkg::RB_SUB_PERASE:
							rb_mode_nxt = fccc_pkg::RB_PERASE;
						fccc_pkg::RB_SUB_OFF:
							rb_mode_nxt = fccc_pkg::RB_OFF;
						default:
							rb_mode_nxt = rb_mode_r;
					endcase
					state_nxt = ST_IDLE;
				end
				default:
					state_nxt = ST_IDLE;
			endcase
		end
	end

	// Sequencer and request registers
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state_r <= ST_IDLE;
			rb_mode_r <= fccc_pkg::RB_LEVEL;
			rd_mode_r <= fccc_pkg::RD_ARRAY;
			req_r <= '{valid: 1'b0, op: fccc_pkg::OP_NONE,
				addr: 16'h0000, aux: 16'h0000, data: 8'h00};
			lo_addr_r <= 16'h0000;
			cnt_r <= 8'h00;
		end
		else
		begin
			state_r <= state_nxt;
			rb_mode_r <= rb_mode_nxt;
			rd_mode_r <= rd_mode_nxt;
			req_r <= req_nxt;
			lo_addr_r <= lo_addr_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Management register writes
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			wp_r <= fccc_pkg::WP_RESET;
			vgen_r <= fccc_pkg::VC_GEN_RESET;
			locks_r <= 1'b0;
			attr_wr_r <= 1'b0;
		end
		else
		begin
			if (attr_wr && hit_wp)
				wp_r <= wd[fccc_pkg::WP_BITS-1:0];
			if (attr_wr && hit_vc)
				vgen_r <= wd[fccc_pkg::VC_GEN];
			if (req_nxt.valid && req_nxt.op == fccc_pkg::OP_UPLOAD)
				locks_r <= 1'b1;
			attr_wr_r <= attr_wr && in_acis &&
				!wp_r[fccc_pkg::WP_CIS];
		end
	end

	// Read data mux, registered toward the pins
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			dout_r <= 8'h00;
		else if (!sync2_r.reg_n)
		begin
			// Status with ready in bit 0
			if (sync2_r.addr == fccc_pkg::CARD_STATUS_ADDR)
				dout_r <= card_status;
			else if (sync2_r.addr == fccc_pkg::WR_PROT_ADDR)
				dout_r <= {5'h00, wp_r};
			else if (sync2_r.addr == fccc_pkg::VOLT_CTRL_ADDR)
				dout_r <= volt_ctrl;
			else
				dout_r <= 8'h00;
		end
		else
		begin
			case (rd_mode_r)
				fccc_pkg::RD_ID: dout_r <= id_rdata;
				fccc_pkg::RD_CSR: dout_r <= csr_rdata;
				fccc_pkg::RD_EXT: dout_r <= ext_view;
				default: dout_r <= array_rdata;
			endcase
		end
	end

	// Ready/busy pulse on completion of the chosen op kind
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			busy_prev_r <= 1'b0;
			last_erase_r <= 1'b0;
			pulse_r <= 4'h0;
		end
		else
		begin
			busy_prev_r <= s_busy;
			if (req_r.valid && (req_r.op == fccc_pkg::OP_ERASE ||
				req_r.op == fccc_pkg::OP_ERASE_ALL))
				last_erase_r <= 1'b1;
			else if (req_r.valid && (req_r.op == fccc_pkg::OP_WRITE ||
				req_r.op == fccc_pkg::OP_PB_XFER))
				last_erase_r <= 1'b0;
			if (busy_prev_r && !s_busy &&
				((rb_mode_r == fccc_pkg::RB_PWRITE && !last_erase_r) ||
				(rb_mode_r == fccc_pkg::RB_PERASE && last_erase_r)))
				pulse_r <= fccc_pkg::RB_PULSE_LEN;
			else if (pulse_r != 4'h0)
				pulse_r <= pulse_r - 4'h1;
		end
	end

	// Output drive
	assign data_out = dout_r;
	assign data_oe = sel && !sync2_r.oe_n && sync2_r.we_n;
	assign req = req_r;
	assign block_lock_enable = wp_r[fccc_pkg::WP_BLOCK_EN];
	assign prog_voltage_generator_on = vgen_r;
	assign locks_uploaded = locks_r;
	assign attr_write = attr_wr_r;
	assign ready_busy_output = (rb_mode_r == fccc_pkg::RB_LEVEL) ?
		!s_busy : (pulse_r == 4'h0);
endmodule
`default_nettype wire

// [verification/fccc_card_ctrl_sva.sv]
// Port checker bound to the card command interpreter
`timescale 1ns/10ps
`default_nettype none
module fccc_card_ctrl_sva
(
	input wire logic mclk, // Clock
	input wire logic rst, // Reset
	input wire logic ce_n, // Card enable
	input wire logic oe_n, // Output enable
	input wire logic we_n, // Write strobe
	input wire logic data_oe, // Data pins driven
	input wire fccc_pkg::fccc_req_t req, // Array request
	input wire logic block_lock_enable, // Lock enable
	input wire logic prog_voltage_generator_on, // Generator on
	input wire logic locks_uploaded, // Locks loaded
	input wire logic attr_write // Attribute write pulse
);
	logic [3:0] age_r; // Cycles since strobe was low
	logic [3:0] age_nxt; // Next age
	assign age_nxt = !we_n ? 4'h0 : (age_r == 4'hf ? age_r : age_r + 4'h1);
	// Saturating age; a late output move means a stray update
	always_ff @(posedge mclk or posedge rst)
		if (rst)
			age_r <= 4'hf;
		else
			age_r <= age_nxt;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_req_one_cycle: assert property (
		req.valid |=> !req.valid)
		else $error("request longer than one cycle");
	a_req_after_write: assert property (
		req.valid |-> age_r inside {[2:9]})
		else $error("request not tied to a write");
	a_attr_one_pulse: assert property (
		attr_write |=> !attr_write)
		else $error("attribute write pulse too long");
	a_attr_after_write: assert property (
		attr_write |-> age_r inside {[2:9]})
		else $error("attribute write without host write");
	a_gen_by_write: assert property (
		$changed(prog_voltage_generator_on) |-> age_r inside {[2:9]})
		else $error("generator moved without write");
	a_lock_by_write: assert property (
		$changed(block_lock_enable) |-> age_r inside {[2:9]})
		else $error("lock enable moved without write");
	a_upload_by_cmd: assert property (
		$rose(locks_uploaded) |-> age_r inside {[2:9]})
		else $error("locks uploaded without command");
	a_drive_on_read: assert property (
		data_oe |-> !$past(oe_n, 2) && !$past(ce_n, 2))
		else $error("data driven outside a read");
endmodule
bind fccc_card_ctrl fccc_card_ctrl_sva fccc_card_ctrl_sva_i (
	.mclk(mclk),
	.rst(rst),
	.ce_n(ce_n),
	.oe_n(oe_n),
	.we_n(we_n),
	.data_oe(data_oe),
	.req(req),
	.block_lock_enable(block_lock_enable),
	.prog_voltage_generator_on(prog_voltage_generator_on),
	.locks_uploaded(locks_uploaded),
	.attr_write(attr_write)
);
`default_nettype wire

// [verification/fccc_host.sv]
// Host socket controller model driving the card bus pins
`timescale 1ns/10ps
`default_nettype none
module fccc_host
(
	input wire logic mclk, // Clock
	output logic ce_n, // Card enable
	output logic reg_n, // Attribute select
	output logic oe_n, // Output enable
	output logic we_n, // Write strobe
	output logic [15:0] addr, // Address pins
	output logic [7:0] data_in, // Write data
	output logic rd_smp // Read sample strobe
);
	int slow; // Extra cycles, zero for a prompt host
	initial
	begin
		{ce_n, reg_n, oe_n, we_n, rd_smp} = 5'h1e;
		addr = 16'h0;
		data_in = 8'h0;
		slow = 0;
	end
	// Released lines show the inverse, never a stale value
	task automatic idle(input int n);
		{ce_n, oe_n, we_n} <= 3'h7;
		addr <= ~addr;
		data_in <= ~data_in;
		repeat (n + slow) @(negedge mclk);
	endtask
	// Strobe low then high, address and data held across the rise
	task automatic wr(input logic r, input logic [15:0] a, input logic [7:0] d);
		{ce_n, reg_n, addr, data_in, we_n} <= {1'b0, r, a, d, 1'b0};
		repeat (3 + slow) @(negedge mclk);
		we_n <= 1'b1;
		repeat (3) @(negedge mclk);
		idle(3);
	endtask
	// Output enable held until the card's data has settled
	task automatic rd(input logic r, input logic [15:0] a);
		{ce_n, reg_n, addr, oe_n} <= {1'b0, r, a, 1'b0};
		repeat (5 + slow) @(negedge mclk);
		rd_smp <= 1'b1;
		@(negedge mclk);
		rd_smp <= 1'b0;
		idle(3);
	endtask
endmodule
`default_nettype wire

// [verification/fccc_card_ctrl_test.sv]
// Self-checking bench for the card command interpreter
`timescale 1ns/10ps
`default_nettype none
module fccc_card_ctrl_test;
	logic mclk, rst, ce_n, reg_n, oe_n, we_n, rd_smp; // Clock, reset, pins
	logic [15:0] addr; // Address pins
	logic [7:0] data_in, data_out; // Data pins
	logic data_oe, vcc_3v3, wp_switch, soft_reset_flag, power_down_flag; // Levels
	logic gen_valid, array_busy, block_lock_enable, prog_voltage_generator_on;
	logic locks_uploaded, attr_write, ready_busy_output; // Card outputs
	logic [7:0] array_rdata, id_rdata, csr_rdata, ext_rdata; // Read sources
	fccc_pkg::fccc_req_t req; // Array request
	fccc_pkg::fccc_req_t eq[$], mq[$]; // Expected requests, masks
	logic [7:0] dq[$]; // Expected read data
	int bad_count, checked, cyc, attrs; // Counters
	logic [15:0] rt [4] = '{16'hff5a, 16'h90a5, 16'h703c, 16'h71c3}; // Code, data
	logic [23:0] ct [7] = '{24'h20d002, 24'ha7d003, 24'hb00004, 24'hd00005,
		24'h500006, 24'h97d00a, 24'h203300}; // Codes, op
	fccc_card_ctrl fccc_card_ctrl_i (.mclk(mclk), .rst(rst), .ce_n(ce_n),
		.reg_n(reg_n), .oe_n(oe_n), .we_n(we_n), .addr(addr), .data_in(data_in),
		.data_out(data_out), .data_oe(data_oe), .vcc_3v3(vcc_3v3),
		.wp_switch(wp_switch), .soft_reset_flag(soft_reset_flag),
		.power_down_flag(power_down_flag), .gen_valid(gen_valid),
		.array_busy(array_busy), .array_rdata(array_rdata), .id_rdata(id_rdata),
		.csr_rdata(csr_rdata), .ext_rdata(ext_rdata), .req(req),
		.block_lock_enable(block_lock_enable),
		.prog_voltage_generator_on(prog_voltage_generator_on),
		.locks_uploaded(locks_uploaded), .attr_write(attr_write),
		.ready_busy_output(ready_busy_output));
	fccc_host fccc_host_i (.mclk(mclk), .ce_n(ce_n), .reg_n(reg_n), .oe_n(oe_n),
		.we_n(we_n), .addr(addr), .data_in(data_in), .rd_smp(rd_smp));
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	task automatic chk(input logic [44:0] seen, input logic [44:0] exp);
		checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		chk(45'(eq.size() + dq.size()), 45'h0);
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Note an expected request; mask bits pick addr, aux, data
	task automatic ex(input logic [3:0] op, input logic [15:0] a,
		input logic [15:0] x, input logic [7:0] d, input logic [2:0] m);
		fccc_pkg::fccc_req_t k;
		k = {5'h1f, {16{m[2]}}, {16{m[1]}}, {8{m[0]}}};
		eq.push_back({1'b1, op, a, x, d} & k);
		mq.push_back(k);
	endtask
	task automatic w(input logic r, input logic [15:0] a, input logic [7:0] d);
		fccc_host_i.wr(r, a, d);
	endtask
	task automatic rd(input logic r, input logic [15:0] a, input logic [7:0] e);
		dq.push_back(e);
		fccc_host_i.rd(r, a);
	endtask
	// Monitor pairs each result with the oldest note; also the time limit
	always @(posedge mclk)
	begin
		cyc++;
		attrs += (attr_write === 1'b1);
		if (req.valid !== 1'b0)
		begin
			chk(req & mq[0], eq.size() ? eq[0] : 45'h0);
			if (eq.size())
			begin
				eq.delete(0);
				mq.delete(0);
			end
		end
		if (rd_smp === 1'b1)
		begin
			chk(45'(data_out), 45'(dq[0]));
			dq.delete(0);
		end
		if (cyc == 20000)
		begin
			bad_count++;
			complete_run();
		end
	end
	initial
	begin
		logic [7:0] v, sr;
		logic [15:0] a;
		int n, j, k;
		{rst, vcc_3v3, gen_valid, array_busy, wp_switch} = 5'h1c;
		{soft_reset_flag, power_down_flag} = 2'h0;
		{array_rdata, id_rdata, csr_rdata, ext_rdata} = 32'h5aa53c83;
		{bad_count, checked, cyc, attrs} = '0;
		void'($urandom(32'hbf2a));
		repeat (16) @(negedge mclk);
		rst = 1'b0;
		repeat (2) @(negedge mclk);
		// supply level and read-only top bit
		rd(0, 16'h410c, 8'h82);
		w(0, 16'h410c, 8'h01);
		rd(0, 16'h410c, 8'h83);
		chk(45'(prog_voltage_generator_on), 45'h1);
		{gen_valid, vcc_3v3} = 2'h0;
		rd(0, 16'h410c, 8'h01);
		w(0, 16'h410c, 8'h80);
		rd(0, 16'h410c, 8'h00);
		rd(0, 16'h4108, 8'h00);
		for (n = 0; n < 8; n++)
		begin
			v = 8'($urandom);
			sr = 8'($urandom);
			{wp_switch, array_busy, power_down_flag, soft_reset_flag} = sr[4:1];
			fccc_host_i.slow = n % 3;
			a = sr[5] ? 16'h0100 : 16'h0800;
			w(0, 16'h4104, v);
			rd(0, 16'h4104, {5'h0, v[2:0]});
			chk(45'(block_lock_enable), 45'(v[2]));
			rd(0, 16'h4100, {2'h0, sr[1], v[1], sr[2], v[0], sr[4], ~sr[3]});
			k = attrs;
			w(0, 16'h0020, v);
			chk(45'(attrs - k), 45'(!v[0]));
			if (!v[1] || a < 16'h0400)
				ex(4'h1, a, 16'h0, sr, 3'h5);
			w(1, a, n[0] ? 8'h10 : 8'h40);
			w(1, a, sr);
		end
		w(0, 16'h4104, 8'h00);
		{wp_switch, array_busy, power_down_flag, soft_reset_flag} = 4'h0;
		for (n = 0; n < 4; n++)
		begin
			w(1, 16'h0200, rt[n][15:8]);
			rd(1, 16'h0202, rt[n][7:0]);
		end
		for (n = 0; n < 7; n++)
		begin
			if (ct[n][3:0] != 4'h0)
				ex(ct[n][3:0], 16'h0, 16'h0, 8'h0, 3'h0);
			w(1, 16'h1000, ct[n][23:16]);
			if (ct[n][15:8] != 8'h00)
				w(1, 16'h1000, ct[n][15:8]);
		end
		chk(45'(locks_uploaded), 45'h1);
		w(1, 16'h0200, 8'h71);
		rd(1, 16'h0202, 8'h83);
		ex(4'h8, 16'h0, 16'h0, 8'h77, 3'h1);
		w(1, 16'h1000, 8'h74);
		w(1, 16'h0030, 8'h77);
		v = 8'($urandom);
		ex(4'h9, 16'h0, 16'h2223, v, 3'h3);
		w(1, 16'h2222, 8'h0c);
		w(1, 16'h2222, v);
		w(1, 16'h2223, 8'h00);
		// counts then count plus one loads
		ex(4'h7, 16'h0, 16'h0002, 8'h0, 3'h2);
		w(1, 16'h3000, 8'he0);
		w(1, 16'h3000, 8'h02);
		w(1, 16'h3000, 8'h00);
		for (n = 0; n < 3; n++)
		begin
			ex(4'h8, 16'h0, 16'h0, 8'(n + 9), 3'h1);
			w(1, 16'(16'h3000 + n), 8'(n + 9));
		end
		for (n = 0; n < 4; n++)
		begin
			// erase first, so erase-pulse mode sees an erase end
			if (n == 2)
			begin
				ex(4'h2, 16'h0, 16'h0, 8'h0, 3'h0);
				w(1, 16'h1000, 8'h20);
				w(1, 16'h1000, 8'hd0);
			end
			w(1, 16'h1000, 8'h96);
			w(1, 16'h1000, 8'(n + 1));
			array_busy = 1'b1;
			k = 0;
			for (j = 0; j < 24; j++)
			begin
				if (j == 8)
					array_busy = 1'b0;
				@(negedge mclk);
				k += (ready_busy_output === 1'b0);
			end
			chk(45'(k), n == 0 ? 45'h8 : (n == 3 ? 45'h0 : 45'h5));
		end
		complete_run();
	end
endmodule
`default_nettype wire
